// [dv/display_sink_model.sv]
// two display sinks that raise hot-plug when the bench plugs them in
// assumes the bench clock; hot-plug moves one edge after the plug request
`timescale 1ns/1ns
`default_nettype none
module display_sink_model (
  input wire logic clk_in,
  input wire logic [1:0] plug_in,
  output logic hot_plug_1_out,
  output logic hot_plug_2_out
);
  always_ff @(posedge clk_in) {hot_plug_2_out, hot_plug_1_out} <= plug_in;
endmodule
`default_nettype wire

// [dv/test_tmds_port_select_control.sv]
// self-checking bench for the port select control block
// assumes the sink model drives hot-plug; outputs settle within 6 edges
`timescale 1ns/1ns
`default_nettype none
module test_tmds_port_select_control;
  import tmds_ctl_pkg::*;
  logic clk = 0, rst_n = 0, oe = 0, ms = 0, dr = 0, pc = 0, st = 0, cd = 1;
  logic el = 0, eh = 0, sl = 0, sh = 0, hp1, hp2, mir, hs, hs_oe;
  logic [1:0] plug = 0, sw;
  logic [3:0] addr;
  logic [7:0] cfg = 0, rx = 0;
  logic [31:0] seed = 32'h0001330C;
  out_ctl_t ctl;
  emphasis_t emp;
  int num_errors = 0, n_compared = 0;
  display_sink_model display_sink_model_i (.clk_in(clk), .plug_in(plug),
    .hot_plug_1_out(hp1), .hot_plug_2_out(hp2));
  tmds_port_select_control tmds_port_select_control_i (.ref_clk_in(clk), .resetn_in(rst_n),
    .output_enable_in(oe), .control_source_select_in(ms), .broadcast_select_in(dr),
    .port_choice_pin_in(pc), .second_port_choice_pin_in(1'b0), .emphasis_bit_low_in(el),
    .emphasis_bit_high_in(eh), .swing_bit_low_in(sl), .swing_bit_high_in(sh),
    .source_term_select_in(st), .clock_detect_in(cd), .hot_plug_in_1_in(hp1),
    .hot_plug_in_2_in(hp2), .config_reg_in(cfg), .rx_setup_reg_in(rx), .ctl_out(ctl),
    .emphasis_out(emp), .swing_out(sw), .i2c_address_out(addr), .port1_mirror_out(mir),
    .hot_plug_to_source_out(hs), .hot_plug_to_source_oe_out(hs_oe));
  initial forever #5 clk = ~clk;
  // expected {port 2, port 1} enables from pins or register bits and plug state
  function automatic logic [1:0] ports();
    return {2{oe}} & plug & (ms ? {cfg[4], cfg[5]} : {dr | pc, dr | !pc});
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: %h not %h", $time, seen, want);
    end
  endtask
  task automatic test_done;
    $display("errors %0d of %0d compares", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // settle past the synchronisers, then look off the edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    repeat (150) begin
      @(posedge clk);
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      {ms, dr, pc, st, el, eh, sl, sh, plug} <= seed[9:0];
      oe <= |seed[11:10];
      cfg <= seed[31:24];
      hold(6);
      chk({ctl.port2_en, ctl.port1_en}, ports());
      chk(hs_oe, !(|ports()));
      chk({ctl.rx_on, ctl.src_term_on, ctl.in_term_on}, {oe, oe & st, oe});
      chk(mir, cfg[5]);
      chk({ctl.drivers_on, ctl.open_drain, ctl.squelch}, {oe, !st, 1'b0});
      chk(hs, 1'b0);
      if (ms) chk(addr, {eh, el, sh, sl});
      else chk({sw, emp}, {sh, sl, eh, el});
    end
    @(posedge clk);
    {oe, ms, dr, plug, cd} <= 6'h2E;
    hold(8);
    chk({ctl.squelch, ctl.port2_en, ctl.port1_en, ctl.in_term_on}, 8'h9);
    chk(ctl.drivers_on, 1'b0);
    @(posedge clk);
    rx <= 8'h02;
    hold(6);
    chk({ctl.squelch, ctl.port2_en, ctl.port1_en}, 8'h3);
    @(posedge clk);
    cd <= 1;
    rx <= 8'h00;
    hold(8);
    chk({ctl.squelch, ctl.port2_en, ctl.port1_en}, 8'h3);
    @(posedge clk);
    rst_n <= 0;
    hold(2);
    chk(ctl, 8'h00);
    chk(hs_oe, 1'b1);
    test_done;
  end
  // long limit: a stuck run still reaches a failing verdict
  initial begin
    #50000;
    num_errors++;
    test_done;
  end
endmodule
`default_nettype wire

// [dv/tmds_ctl_properties.sv]
// timing relations between the control pins and the decoded outputs
// assumes binding onto the top module; pins reach the outputs after 3 edges
`timescale 1ns/1ns
`default_nettype none
module tmds_ctl_properties import tmds_ctl_pkg::*; (
  input wire logic ref_clk_in, resetn_in, output_enable_in, control_source_select_in,
  input wire logic broadcast_select_in, port_choice_pin_in, source_term_select_in,
  input wire logic emphasis_bit_low_in, emphasis_bit_high_in, hot_plug_in_1_in,
  input wire logic hot_plug_in_2_in, port1_mirror_out, hot_plug_to_source_oe_out,
  input wire logic [7:0] config_reg_in,
  input wire out_ctl_t ctl_out,
  input wire emphasis_t emphasis_out
);
  // history is only trusted once the synchronisers have refilled after reset
  logic [2:0] age_reg;
  logic up;
  always_ff @(posedge ref_clk_in) age_reg <= !resetn_in ? 3'h0 : age_reg + {2'h0, !up};
  assign up = age_reg == 3'h4;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  property p_rx; up |-> ctl_out.rx_on == $past(output_enable_in, 3); endproperty
  a_rx: assert property (p_rx) else $error("receiver enable wrong");
  property p_off; up && !$past(output_enable_in, 3) |-> hot_plug_to_source_oe_out &&
    !ctl_out.port1_en && !ctl_out.port2_en && !ctl_out.in_term_on; endproperty
  a_off: assert property (p_off) else $error("not off with enable low");
  property p_term; up |-> ctl_out.src_term_on ==
    $past(output_enable_in && source_term_select_in, 3); endproperty
  a_term: assert property (p_term) else $error("source termination wrong");
  property p_emp; up && !$past(control_source_select_in, 3) |->
    emphasis_out == $past({emphasis_bit_high_in, emphasis_bit_low_in}, 3); endproperty
  a_emp: assert property (p_emp) else $error("emphasis wrong");
  property p_mir; up |-> port1_mirror_out == $past(config_reg_in[5]); endproperty
  a_mir: assert property (p_mir) else $error("mirror wrong");
  property p_p1; up && !$past(control_source_select_in, 3) && !ctl_out.squelch |->
    ctl_out.port1_en == $past(output_enable_in && hot_plug_in_1_in &&
    (broadcast_select_in || !port_choice_pin_in), 3); endproperty
  a_p1: assert property (p_p1) else $error("port 1 enable wrong");
  property p_hp; up && !$past(control_source_select_in, 3) && !ctl_out.squelch |->
    hot_plug_to_source_oe_out != $past(output_enable_in &&
    ((broadcast_select_in || !port_choice_pin_in) && hot_plug_in_1_in ||
    (broadcast_select_in || port_choice_pin_in) && hot_plug_in_2_in), 3); endproperty
  a_hp: assert property (p_hp) else $error("source hot-plug wrong");
  property p_sq; ctl_out.squelch |-> !ctl_out.port1_en && !ctl_out.port2_en; endproperty
  a_sq: assert property (p_sq) else $error("port on in squelch");
endmodule
bind tmds_port_select_control tmds_ctl_properties tmds_ctl_properties_i (.*);
`default_nettype wire

// [include/tmds_ctl_map.svh]
// constants for the port select control block
// assumes include by bare name; no processes here
// Behaviour
// - pin mode emphasis pins map 00/01/10/11 to 0, 1.5, 2.5, 3.5 dB.
// - output enable low disables ports, receiver, drivers, terminations; source hot-plug 0.
// - pin mode, broadcast high enables both output ports.
// - pin mode, broadcast low: port choice high selects port 2, else port 1.
// - port 1 mirror output follows configuration bit 5.
// - source termination select high connects termination; low gives open-drain drivers.
// - low input clock level squelches and disables outputs; restored above threshold.
// - squelch enabled also enables input termination.
// - squelch disabled with no input leaves data outputs undefined.
// - in squelch, outputs go high impedance or source-terminated pull-up.
// - pin mode hot-plug is OR when broadcast, else selected port's input.
// - register mode ignores pins; hot-plug is OR of hot-plug AND port enable.
// - selected port counts enabled only while its hot-plug input is 1.
// - register mode turns shared pins into address bits; pin mode uses them as controls.
// - register mode: configuration bits 5 and 4 enable ports 1 and 2.
// - receiver setup bit 1 zero enables squelch, one disables it.
`ifndef TMDS_CTL_MAP_SVH
`define TMDS_CTL_MAP_SVH
`define CFG_PORT1_BIT 5
`define CFG_PORT2_BIT 4
`define RXSET_SQUELCH_OFF_BIT 1
`define CFG_RESET 8'hFF
`define RXSET_RESET 8'h00
`define EMP_0DB 2'h0
`define EMP_1P5DB 2'h1
`define EMP_2P5DB 2'h2
`define EMP_3P5DB 2'h3
`define RXSET_IN_TERM_OFF_BIT 7
`define PIN_OUT_EN 13
`define PIN_CTL_SRC 12
`define PIN_BCAST 11
`define PIN_CHOICE 10
`define PIN_CHOICE2 9
`define PIN_EMP_LO 8
`define PIN_EMP_HI 7
`define PIN_SW_LO 6
`define PIN_SW_HI 5
`define PIN_TERM 4
`define PIN_CLK_DET 3
`define PIN_HP1 2
`define PIN_HP2 1
`define PIN_SPARE 0
`endif

// [include/tmds_ctl_pkg.sv]
// types for the port select control block
// assumes a single reference clock domain
package tmds_ctl_pkg;
  typedef enum logic [1:0] {
    EMPH_0DB = 2'h0,
    EMPH_1P5DB = 2'h1,
    EMPH_2P5DB = 2'h2,
    EMPH_3P5DB = 2'h3
  } emphasis_t;
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'h1,
    ST_SQUELCH = 2'h2
  } squelch_state_t;
  typedef struct packed {
    logic port1_en;
    logic port2_en;
    logic rx_on;
    logic drivers_on;
    logic src_term_on;
    logic open_drain;
    logic in_term_on;
    logic squelch;
  } out_ctl_t;
endpackage

// [rtl/tmds_port_select_control.sv]
// port enable, hot-plug, termination and squelch control for a 1:2 splitter
// assumes pins are asynchronous and are synchronised here; registers come
// from an external serial-register slave on the same clock
`include "tmds_ctl_map.svh"
`timescale 1ns/1ns
`default_nettype none
module tmds_port_select_control (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // strap pins
  input wire logic output_enable_in,
  input wire logic control_source_select_in,
  input wire logic broadcast_select_in,
  input wire logic port_choice_pin_in,
  input wire logic second_port_choice_pin_in,
  input wire logic emphasis_bit_low_in,
  input wire logic emphasis_bit_high_in,
  input wire logic swing_bit_low_in,
  input wire logic swing_bit_high_in,
  input wire logic source_term_select_in,
  input wire logic clock_detect_in,
  // display hot-plug pins
  input wire logic hot_plug_in_1_in,
  input wire logic hot_plug_in_2_in,
  // register contents, same clock domain
  input wire logic [7:0] config_reg_in,
  input wire logic [7:0] rx_setup_reg_in,
  // decoded controls
  output var tmds_ctl_pkg::out_ctl_t ctl_out,
  output tmds_ctl_pkg::emphasis_t emphasis_out,
  output logic [1:0] swing_out,
  output logic [3:0] i2c_address_out,
  output logic port1_mirror_out,
  output logic hot_plug_to_source_out,
  output logic hot_plug_to_source_oe_out
);
  import tmds_ctl_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int NPIN = 14;
  logic [NPIN-1:0] pins_raw;
  logic [NPIN-1:0] sync1_reg;
  logic [NPIN-1:0] sync2_reg;
  logic [NPIN-1:0] sync1_next;
  logic [NPIN-1:0] sync2_next;
  assign pins_raw[`PIN_OUT_EN] = output_enable_in;
  assign pins_raw[`PIN_CTL_SRC] = control_source_select_in;
  assign pins_raw[`PIN_BCAST] = broadcast_select_in;
  assign pins_raw[`PIN_CHOICE] = port_choice_pin_in;
  assign pins_raw[`PIN_CHOICE2] = second_port_choice_pin_in;
  assign pins_raw[`PIN_EMP_LO] = emphasis_bit_low_in;
  assign pins_raw[`PIN_EMP_HI] = emphasis_bit_high_in;
  assign pins_raw[`PIN_SW_LO] = swing_bit_low_in;
  assign pins_raw[`PIN_SW_HI] = swing_bit_high_in;
  assign pins_raw[`PIN_TERM] = source_term_select_in;
  assign pins_raw[`PIN_CLK_DET] = clock_detect_in;
  assign pins_raw[`PIN_HP1] = hot_plug_in_1_in;
  assign pins_raw[`PIN_HP2] = hot_plug_in_2_in;
  assign pins_raw[`PIN_SPARE] = 1'b0;

  // one two-flop synchroniser per pin; cleared so the port, receiver, driver and termination enables start off
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_comb begin
      sync1_next[i] = pins_raw[i];
      sync2_next[i] = sync1_reg[i];
    end

    always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
        sync1_reg[i] <= 1'b0;
        sync2_reg[i] <= 1'b0;
      end else begin
        sync1_reg[i] <= sync1_next[i];
        sync2_reg[i] <= sync2_next[i];
      end
    end
  end

  logic oe_s, ms_s, bc_s, sel_s, emp_lo_s, emp_hi_s, sw_lo_s, sw_hi_s;
  logic rterm_s, clkdet_s, hp1_s, hp2_s;
  assign oe_s = sync2_reg[`PIN_OUT_EN];
  assign ms_s = sync2_reg[`PIN_CTL_SRC];
  assign bc_s = sync2_reg[`PIN_BCAST];
  assign sel_s = sync2_reg[`PIN_CHOICE];
  assign emp_lo_s = sync2_reg[`PIN_EMP_LO];
  assign emp_hi_s = sync2_reg[`PIN_EMP_HI];
  assign sw_lo_s = sync2_reg[`PIN_SW_LO];
  assign sw_hi_s = sync2_reg[`PIN_SW_HI];
  assign rterm_s = sync2_reg[`PIN_TERM];
  assign clkdet_s = sync2_reg[`PIN_CLK_DET];
  assign hp1_s = sync2_reg[`PIN_HP1];
  assign hp2_s = sync2_reg[`PIN_HP2];
  // second port choice pin is don't-care in every documented mode

  // ----------------------------------------
  // squelch state
  // ----------------------------------------
  squelch_state_t sq_reg;
  squelch_state_t sq_next;
  logic squelch_en;
  assign squelch_en = !rx_setup_reg_in[`RXSET_SQUELCH_OFF_BIT];

  always_comb begin
    case (sq_reg)
      ST_ACTIVE: sq_next = (squelch_en && !clkdet_s) ? ST_SQUELCH : ST_ACTIVE;
      ST_SQUELCH: sq_next = (!squelch_en || clkdet_s) ? ST_ACTIVE : ST_SQUELCH;
      default: sq_next = ST_SQUELCH;
    endcase
  end

  // with squelch disabled, no-input data outputs are undefined by design
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      sq_reg <= ST_SQUELCH;
    end else begin
      sq_reg <= sq_next;
    end
  end

  // ----------------------------------------
  // port selection
  // ----------------------------------------
  logic port_choice_pin;
  logic second_port_choice_pin;
  logic hp_port_choice_pin;
  logic hp_second_port_choice_pin;

  // selection is pure decode, so a pin or register change needs no command
  always_comb begin
    if (ms_s) begin
      port_choice_pin = config_reg_in[`CFG_PORT1_BIT];
      second_port_choice_pin = config_reg_in[`CFG_PORT2_BIT];
    end else if (bc_s) begin
      port_choice_pin = 1'b1;
      second_port_choice_pin = 1'b1;
    end else begin
      port_choice_pin = !sel_s;
      second_port_choice_pin = sel_s;
    end
    hp_port_choice_pin = hp1_s && port_choice_pin;
    hp_second_port_choice_pin = hp2_s && second_port_choice_pin;
  end

  // ----------------------------------------
  // hot-plug toward the source
  // ----------------------------------------
  logic hp_next;
  logic hp_reg;

  always_comb begin
    hp_next = hp_port_choice_pin || hp_second_port_choice_pin;
    if (!oe_s) begin
      hp_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      hp_reg <= 1'b0;
    end else begin
      hp_reg <= hp_next;
    end
  end

  // ----------------------------------------
  // port, driver and termination controls
  // ----------------------------------------
  out_ctl_t ctl_next;
  out_ctl_t ctl_reg;

  always_comb begin
    ctl_next.squelch = (sq_reg == ST_SQUELCH);
    // a selected port only drives while its display is present
    ctl_next.port1_en = oe_s && port_choice_pin && hp1_s && !ctl_next.squelch;
    ctl_next.port2_en = oe_s && second_port_choice_pin && hp2_s && !ctl_next.squelch;
    ctl_next.rx_on = oe_s;
    ctl_next.drivers_on = oe_s && !ctl_next.squelch;
    // squelched outputs keep source termination as a pull-up when selected
    ctl_next.src_term_on = oe_s && rterm_s;
    ctl_next.open_drain = !rterm_s;
    // squelch enable forces input termination on, else the register bit decides
    ctl_next.in_term_on = oe_s &&
      (squelch_en || !rx_setup_reg_in[`RXSET_IN_TERM_OFF_BIT]);
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      ctl_reg <= '0;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // ----------------------------------------
  // emphasis from the shared pins
  // ----------------------------------------
  // register mode borrows the pins, so the last pin-mode setting is kept
  emphasis_t emph_next;
  emphasis_t emph_reg;

  always_comb begin
    if (ms_s) begin
      emph_next = emph_reg;
    end else begin
      emph_next = emphasis_t'({emp_hi_s, emp_lo_s});
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      emph_reg <= EMPH_0DB;
    end else begin
      emph_reg <= emph_next;
    end
  end

  // ----------------------------------------
  // swing from the shared pins
  // ----------------------------------------
  // same hold-over as emphasis while the pins carry the address
  logic [1:0] swing_next;
  logic [1:0] swing_reg;

  always_comb begin
    if (ms_s) begin
      swing_next = swing_reg;
    end else begin
      swing_next = {sw_hi_s, sw_lo_s};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      swing_reg <= '0;
    end else begin
      swing_reg <= swing_next;
    end
  end

  // ----------------------------------------
  // serial address from the shared pins
  // ----------------------------------------
  // pin mode leaves the last captured address in place
  logic [3:0] addr_next;
  logic [3:0] addr_reg;

  always_comb begin
    if (ms_s) begin
      addr_next = {emp_hi_s, emp_lo_s, sw_hi_s, sw_lo_s};
    end else begin
      addr_next = addr_reg;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      addr_reg <= '0;
    end else begin
      addr_reg <= addr_next;
    end
  end

  // ----------------------------------------
  // port 1 mirror
  // ----------------------------------------
  // registered so the pin never glitches while the register is rewritten
  logic mirror_next;
  logic mirror_reg;

  always_comb begin
    mirror_next = config_reg_in[`CFG_PORT1_BIT];
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      mirror_reg <= 1'b0;
    end else begin
      mirror_reg <= mirror_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign ctl_out = ctl_reg;
  assign emphasis_out = emph_reg;
  assign swing_out = swing_reg;
  assign i2c_address_out = addr_reg;
  assign port1_mirror_out = mirror_reg;
  // open-drain style toward the source: drive low only, external pull-up gives 1
  assign hot_plug_to_source_out = 1'b0;
  assign hot_plug_to_source_oe_out = !hp_reg;
endmodule
`default_nettype wire
